// File: src/adcav_ctrl.sv
/*
 * averaging converter control: staged register writes with busy bits,
 * event arbitration, on-request power and sample averaging.
 * assumes the conversion core pulses conv_done_in with conv_data_in,
 * and that all inputs are synchronous to clk_sys_in.
 */
// What this block does
// R1: with averaging selected, the configured number of samples is summed, divided and stored as the result.
// R2: sample count codes 0x0 to 0x5 select 1 to 32 samples, with a sum of up to 17 bits.
// R3: division is the automatic shift plus the adjust shift, giving a 12-bit result.
// R4: software programs the adjust field 0x0 to 0x4 to match the sample count.
// R5: software selects the averaging resolution before averaging two or more samples.
// R6: averaged results come at the raw conversion rate divided by the sample count.
// R7: the result-ready flag is set when an averaged result reaches the result register.
// R8: any enabled event acts, and flush beats start when both arrive together.
// R9: enable off disables; the two standby bits choose run, on-request or stop in standby.
// R10: on-request mode powers the analog part off after each conversion and waits the start-up time on wake.
// R11: soft reset and enable writes take effect only after the write staging delay.
// R12: writes to the listed registers take effect only after the write staging delay.
// R13: each staged item shows a busy bit until its new value has taken effect.
`timescale 1ns/1ps
`default_nettype none
module adcav_ctrl
    import adcav_pkg::*;
#(
    parameter int RES_W      = 12,
    parameter int STAGES     = SYNC_STAGES,
    parameter int STARTUP    = STARTUP_CYC
) (
    input  wire logic                    clk_sys_in,
    input  wire logic                    rst_n_in,
    input  wire logic [ITEM_N-1:0]       wr_sel_in,
    input  wire logic [REG_W-1:0]        wr_data_in,
    input  wire logic                    keep_running_standby_in,
    input  wire logic                    on_request_clocking_in,
    input  wire logic                    standby_in,
    input  wire logic                    evt_start_in,
    input  wire logic                    evt_flush_in,
    input  wire logic                    conv_done_in,
    input  wire logic [RES_W-1:0]        conv_data_in,
    input  wire logic                    flag_clear_in,
    output logic [ITEM_N-1:0]            sync_busy_out,
    output logic [ITEM_N*REG_W-1:0]      applied_regs_out,
    output logic [RES_W-1:0]             result_out,
    output logic                         result_ready_flag_out,
    output logic                         conv_start_out,
    output logic                         analog_power_out
);
    localparam int SUM_W = RES_W + 5;
    localparam int CNT_W = $clog2(STAGES + 1);
    localparam int SU_W  = $clog2(STARTUP + 1);

    // refused at elaboration: the sum width assumes a 12-bit core
    if (RES_W != 12 || STAGES < 1 || STARTUP < 1) begin : g_param_check
        $error("adcav_ctrl: unsupported parameter values");
    end

    logic [ITEM_N*REG_W-1:0] hold_r;
    logic [ITEM_N*CNT_W-1:0] stage_cnt_r;
    logic [ITEM_N-1:0]       apply_now;
    adcav_state_type         state_r;
    logic [SU_W-1:0]         wake_cnt_r;
    logic [SUM_W-1:0]        sum_r;
    logic [5:0]              taken_r;

    function automatic logic [REG_W-1:0] item_of(input logic [ITEM_N*REG_W-1:0] v,
                                                 input int idx);
        item_of = v[idx*REG_W +: REG_W];
    endfunction

    // R11 R12 staging delay reached
    always_comb begin
        for (int i = 0; i < ITEM_N; i++) begin
            apply_now[i] = sync_busy_out[i] && !wr_sel_in[i]
                && (stage_cnt_r[i*CNT_W +: CNT_W] == CNT_W'(STAGES - 1));
        end
    end

    logic [REG_W-1:0] main_ctl;
    logic [REG_W-1:0] avg_ctl;
    logic [REG_W-1:0] ctrl_c;
    logic [REG_W-1:0] trig_hold;
    logic [REG_W-1:0] main_hold;
    logic             soft_rst;
    logic             enable;
    logic             run_ok;
    logic             avg_on;
    logic [3:0]       count_sel;
    logic [2:0]       adj_shift;
    logic [5:0]       n_samples;
    logic             start_req;
    logic             flush_req;

    always_comb begin
        main_ctl  = item_of(applied_regs_out, IDX_MAIN_CONTROL);
        avg_ctl   = item_of(applied_regs_out, IDX_AVERAGING);
        ctrl_c    = item_of(applied_regs_out, IDX_CONTROL_C);
        trig_hold = item_of(hold_r, IDX_SW_TRIGGER);
        main_hold = item_of(hold_r, IDX_MAIN_CONTROL);
        // R11 soft reset acts on apply
        soft_rst  = apply_now[IDX_MAIN_CONTROL] && main_hold[MAIN_SOFT_RESET_BIT];
        enable    = main_ctl[MAIN_ENABLE_BIT];
        // R9 standby behaviour
        run_ok    = enable && (!standby_in || keep_running_standby_in);
        // R5 averaging needs resolution select
        avg_on    = ctrl_c[CONTROL_C_RES_LSB +: 2] == RES_SEL_AVERAGING;
        count_sel = avg_ctl[AVG_COUNT_LSB +: 4];
        adj_shift = avg_ctl[AVG_ADJ_LSB +: 3];
        // R2 count decode, reserved codes clamp to the largest
        if (!avg_on) begin
            n_samples = 6'h01;
        end else if (count_sel > SAMPLE_SEL_MAX) begin
            n_samples = 6'h20;
        end else begin
            n_samples = 6'(6'h01 << count_sel);
        end
        // R8 event sources, flush decided first
        flush_req = evt_flush_in || (apply_now[IDX_SW_TRIGGER] && trig_hold[SOFTWARE_TRIGGER_REG_FLUSH_BIT]);
        start_req = evt_start_in || (apply_now[IDX_SW_TRIGGER] && trig_hold[SOFTWARE_TRIGGER_REG_START_BIT]);
    end

    // R13 busy per item
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_busy_out <= '0;
            stage_cnt_r   <= '0;
            hold_r        <= '0;
        end else begin
            for (int i = 0; i < ITEM_N; i++) begin
                if (wr_sel_in[i]) begin
                    sync_busy_out[i]                <= 1'b1;
                    stage_cnt_r[i*CNT_W +: CNT_W]   <= '0;
                    hold_r[i*REG_W +: REG_W]        <= wr_data_in;
                end else if (apply_now[i]) begin
                    sync_busy_out[i] <= 1'b0;
                end else if (sync_busy_out[i]) begin
                    stage_cnt_r[i*CNT_W +: CNT_W] <= stage_cnt_r[i*CNT_W +: CNT_W] + 1'b1;
                end
            end
        end
    end

    // R12 applied values; soft reset clears enable
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            applied_regs_out <= {ITEM_N{REG_RESET_VALUE}};
        end else if (soft_rst) begin
            applied_regs_out <= {ITEM_N{REG_RESET_VALUE}};
        end else begin
            for (int i = 0; i < ITEM_N; i++) begin
                if (apply_now[i]) begin
                    applied_regs_out[i*REG_W +: REG_W] <= hold_r[i*REG_W +: REG_W];
                end
            end
            // trigger bits are strobes, never held
            applied_regs_out[IDX_SW_TRIGGER*REG_W +: REG_W] <= REG_RESET_VALUE;
        end
    end

    // R8 R9 R10 conversion sequencing
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r          <= ADCAV_IDLE;
            wake_cnt_r       <= '0;
            conv_start_out   <= 1'b0;
            analog_power_out <= 1'b0;
        end else begin
            conv_start_out <= 1'b0;
            if (soft_rst || !run_ok || flush_req) begin
                state_r          <= ADCAV_IDLE;
                analog_power_out <= run_ok && !on_request_clocking_in;
            end else begin
                case (state_r)
                    ADCAV_IDLE: begin
                        analog_power_out <= analog_power_out || !on_request_clocking_in;
                        if (start_req) begin
                            if (analog_power_out) begin
                                conv_start_out <= 1'b1;
                                state_r        <= ADCAV_CONV;
                            end else begin
                                // start-up time only after power-off
                                analog_power_out <= 1'b1;
                                wake_cnt_r       <= '0;
                                state_r          <= ADCAV_WAKE;
                            end
                        end
                    end
                    ADCAV_WAKE: begin
                        if (wake_cnt_r == SU_W'(STARTUP - 1)) begin
                            conv_start_out <= 1'b1;
                            state_r        <= ADCAV_CONV;
                        end else begin
                            wake_cnt_r <= wake_cnt_r + 1'b1;
                        end
                    end
                    ADCAV_CONV: begin
                        if (conv_done_in) begin
                            state_r <= ADCAV_IDLE;
                            if (on_request_clocking_in) begin
                                analog_power_out <= 1'b0;
                            end
                        end
                    end
                    default: state_r <= ADCAV_IDLE;
                endcase
            end
        end
    end

    logic [SUM_W-1:0] sum_next;
    logic             last_sample;
    logic [SUM_W-1:0] shifted;

    always_comb begin
        sum_next    = sum_r + SUM_W'(conv_data_in);
        last_sample = (taken_r + 6'h01) == n_samples;
        // R3 automatic shift then adjust shift
        // shifts only with averaging on, so single samples pass unscaled
        shifted     = sum_next >> ((avg_on && count_sel >= SAMPLE_SEL_AUTO_SHIFT) ? 1 : 0);
        shifted     = avg_on ? (shifted >> adj_shift) : shifted;
    end

    // R1 R6 accumulate and divide
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sum_r      <= '0;
            taken_r    <= '0;
            result_out <= '0;
        end else if (soft_rst || flush_req) begin
            sum_r   <= '0;
            taken_r <= '0;
        end else if (conv_done_in && state_r == ADCAV_CONV) begin
            if (last_sample) begin
                sum_r      <= '0;
                taken_r    <= '0;
                result_out <= shifted[RES_W-1:0];
            end else begin
                sum_r   <= sum_next;
                taken_r <= taken_r + 6'h01;
            end
        end
    end

    // R7 ready flag, set beats flag_clear_in, soft reset beats set
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result_ready_flag_out <= 1'b0;
        end else if (conv_done_in && state_r == ADCAV_CONV && last_sample && !flush_req
                     && !soft_rst) begin
            result_ready_flag_out <= 1'b1;
        end else if (flag_clear_in || soft_rst) begin
            result_ready_flag_out <= 1'b0;
        end
    end

    sequence s_wake_start;
        state_r == ADCAV_WAKE && wake_cnt_r == SU_W'(STARTUP - 1) && run_ok && !flush_req
            && !soft_rst;
    endsequence

    a_result_ready_set: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R7
        conv_done_in && state_r == ADCAV_CONV && last_sample && !flush_req && !soft_rst
        |=> result_ready_flag_out) else $error("ready flag not set on result");
    a_flag_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R7
        result_ready_flag_out && !flag_clear_in && !soft_rst |=> result_ready_flag_out)
        else $error("ready flag lost");
    a_flush_wins: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R8
        flush_req && start_req |=> state_r == ADCAV_IDLE && !conv_start_out)
        else $error("start taken over flush");
    a_disabled_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R9
        !run_ok |=> state_r == ADCAV_IDLE && !conv_start_out) else $error("ran while disabled");
    a_on_request_clocking_off: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R10
        state_r == ADCAV_CONV && conv_done_in && on_request_clocking_in && run_ok
        |=> !analog_power_out) else $error("analog left on after conversion");
    a_wake_delay: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R10
        s_wake_start |=> conv_start_out && state_r == ADCAV_CONV) else $error("wake start wrong");
    a_sync_busy_len: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R13
        wr_sel_in[IDX_AVERAGING] |=> sync_busy_out[IDX_AVERAGING][*1] ##(STAGES - 1)
        sync_busy_out[IDX_AVERAGING] || wr_sel_in[IDX_AVERAGING])
        else $error("busy dropped early");
    a_sync_applied: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R12
        apply_now[IDX_CONTROL_C] && !soft_rst |=> ctrl_c == $past(item_of(hold_r, IDX_CONTROL_C))
        && !sync_busy_out[IDX_CONTROL_C]) else $error("staged value not applied");
    a_result_width: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R3
        conv_done_in && state_r == ADCAV_CONV && !avg_on && !flush_req && !soft_rst
        |=> result_out == $past(conv_data_in)) else $error("single sample not passed");
endmodule
`default_nettype wire

// File: inc/adcav_pkg.sv
/*
 * constants for the averaging converter control: write-item indices,
 * field positions, codes and timing counts.
 * assumes a 100 MHz system clock and a 12-bit conversion core.
 */
package adcav_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int STARTUP_TIME_NS = 1000;
    localparam int STARTUP_CYC = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;

    localparam int REG_W = 16;
    localparam int ITEM_N = 10;
    localparam int IDX_INPUT_SELECT = 0;
    localparam int IDX_CONTROL_C = 1;
    localparam int IDX_AVERAGING = 2;
    localparam int IDX_SAMPLING_TIME = 3;
    localparam int IDX_WIN_LOWER = 4;
    localparam int IDX_WIN_UPPER = 5;
    localparam int IDX_GAIN_CORR = 6;
    localparam int IDX_OFFSET_CORR = 7;
    localparam int IDX_SW_TRIGGER = 8;
    localparam int IDX_MAIN_CONTROL = 9;

    localparam int MAIN_SOFT_RESET_BIT = 0;
    localparam int MAIN_ENABLE_BIT = 1;
    localparam int SOFTWARE_TRIGGER_REG_FLUSH_BIT = 0;
    localparam int SOFTWARE_TRIGGER_REG_START_BIT = 1;
    localparam int AVG_COUNT_LSB = 0;
    localparam int AVG_ADJ_LSB = 4;
    localparam int CONTROL_C_RES_LSB = 4;

    localparam logic [1:0] RES_SEL_AVERAGING = 2'h1;
    localparam logic [3:0] SAMPLE_SEL_MAX = 4'h5;
    localparam logic [3:0] SAMPLE_SEL_AUTO_SHIFT = 4'h5;
    localparam logic [15:0] REG_RESET_VALUE = 16'h0000;

    typedef enum logic [2:0] {
        ADCAV_IDLE = 3'b001,
        ADCAV_WAKE = 3'b010,
        ADCAV_CONV = 3'b100
    } adcav_state_type;
endpackage

// File: dv/adcav_core_model.sv
/*
 * conversion core model: answers each start pulse delay_in + 1 cycles after it is taken
 * with one done pulse carrying sample_in.
 * assumes start pulses come on the rising edge of clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module adcav_core_model (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        start_in,
    input  wire logic [7:0]  delay_in,
    input  wire logic [11:0] sample_in,
    output logic             done_out,
    output logic [11:0]      data_out
);
    logic [7:0] cnt_r;
    logic       busy_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_r   <= 1'b0;
            cnt_r    <= 8'h00;
            done_out <= 1'b0;
            data_out <= 12'h000;
        end else begin
            done_out <= 1'b0;
            // data is only valid with done, so it churns otherwise
            data_out <= ~data_out;
            if (start_in) begin
                busy_r <= 1'b1;
                cnt_r  <= delay_in;
            end else if (busy_r && cnt_r == 8'h00) begin
                busy_r   <= 1'b0;
                done_out <= 1'b1;
                data_out <= sample_in;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/adc_result_averaging_control_tb.sv
/*
 * bench for the averaging control: staged writes, averaging, event
 * priority, standby gating, on-request power and soft reset.
 * assumes the core model answers each start after a fixed delay.
 */
`timescale 1ns/1ps
`default_nettype none
module adc_result_averaging_control_tb;
    import adcav_pkg::*;
    localparam int SU = 3;
    logic                    clk_sys_in = 1'b0;
    logic                    rst_n_in = 1'b0;
    logic [ITEM_N-1:0]       wr_sel = '0;
    logic [REG_W-1:0]        wr_data = '0;
    logic                    keep_run = 1'b0;
    logic                    on_req = 1'b0;
    logic                    standby = 1'b0;
    logic                    evt_start = 1'b0;
    logic                    evt_flush = 1'b0;
    logic                    flag_clr = 1'b0;
    logic                    done;
    logic                    start;
    logic                    flag;
    logic                    power;
    logic [11:0]             data;
    logic [11:0]             result;
    logic [11:0]             sample = 12'h000;
    logic [ITEM_N-1:0]       busy;
    logic [ITEM_N*REG_W-1:0] applied;
    int                      error_cnt = 0;
    int                      checked = 0;
    int                      starts = 0;

    adcav_ctrl #(.STARTUP(SU)) dut (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wr_sel_in(wr_sel),
        .wr_data_in(wr_data), .keep_running_standby_in(keep_run),
        .on_request_clocking_in(on_req), .standby_in(standby),
        .evt_start_in(evt_start), .evt_flush_in(evt_flush), .conv_done_in(done),
        .conv_data_in(data), .flag_clear_in(flag_clr), .sync_busy_out(busy),
        .applied_regs_out(applied), .result_out(result),
        .result_ready_flag_out(flag), .conv_start_out(start),
        .analog_power_out(power));

    adcav_core_model core (
        .clk_in(clk_sys_in), .rst_n_in(rst_n_in), .start_in(start),
        .delay_in(8'h04), .sample_in(sample), .done_out(done), .data_out(data));

    always #5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) if (start === 1'b1) starts++;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input int idx, input logic [15:0] d, input int hold);
        @(negedge clk_sys_in);
        wr_sel[idx] <= 1'b1;
        wr_data     <= d;
        @(negedge clk_sys_in);
        wr_sel <= '0;
        repeat (hold) @(negedge clk_sys_in);
    endtask

    task automatic pulse_evt(input logic s, input logic f);
        @(negedge clk_sys_in);
        evt_start <= s;
        evt_flush <= f;
        @(negedge clk_sys_in);
        evt_start <= 1'b0;
        evt_flush <= 1'b0;
    endtask

    // waits for the core answer under a bound, then lets the result land
    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 60) begin
            @(negedge clk_sys_in);
            n++;
        end
        check("conversion done", n < 60, 1); // conversion answered
        repeat (2) @(negedge clk_sys_in);
    endtask

    task automatic try_start(input logic exp);
        int s0;
        s0 = starts;
        pulse_evt(1'b1, 1'b0);
        repeat (30) @(negedge clk_sys_in);
        check("start taken", starts - s0, exp); // run gating
    endtask

    task automatic lat(output int n);
        pulse_evt(1'b1, 1'b0);
        n = 1;
        while (start !== 1'b1 && n < 40) begin
            @(negedge clk_sys_in);
            n++;
        end
        repeat (20) @(negedge clk_sys_in);
    endtask

    task automatic avg_run(input int n, input int shift, input logic [11:0] base);
        logic [16:0] sum;
        int          s0;
        logic [11:0] v;
        sum = '0;
        s0 = starts;
        // the flag is sticky, so clear what an earlier result left
        @(negedge clk_sys_in);
        flag_clr <= 1'b1;
        @(negedge clk_sys_in);
        flag_clr <= 1'b0;
        for (int k = 0; k < n; k++) begin
            if (k == n - 1 && n > 1) check("flag early", flag, 0); // flag timing
            // samples wrap at 12 bits, as the core would deliver them
            v = base + 12'(k * 37);
            sample <= v;
            pulse_evt(1'b1, 1'b0);
            wait_done();
            sum = sum + 17'(v);
        end
        check("averaged result", result, 32'(sum >> shift)); // average
        check("result flag", flag, 1); // flag set
        check("starts per result", starts - s0, n); // rate
    endtask

    initial begin
        int n;
        repeat (20) @(negedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(negedge clk_sys_in);
        check("reset outputs", {flag, power, start, result}, 0); // idle after reset
        wr(IDX_SAMPLING_TIME, 16'h00a5, 1);
        check("busy staging", busy[IDX_SAMPLING_TIME], 1); // busy
        check("old value", applied[IDX_SAMPLING_TIME*REG_W +: REG_W], 0); // staging
        repeat (2) @(negedge clk_sys_in);
        check("busy cleared", busy[IDX_SAMPLING_TIME], 0); // busy
        check("new value", applied[IDX_SAMPLING_TIME*REG_W +: REG_W], 16'h00a5); // staging
        try_start(1'b0); // disabled
        wr(IDX_MAIN_CONTROL, 16'h0002, 3);
        check("enable applied", applied[IDX_MAIN_CONTROL*REG_W +: REG_W], 2); // enable
        sample <= 12'h3c1;
        wr(IDX_SW_TRIGGER, 16'h0002, 0);
        wait_done();
        check("single result", result, 12'h3c1); // trigger
        wr(IDX_CONTROL_C, 16'h0010, 3); // averaging resolution
        wr(IDX_AVERAGING, 16'h0022, 3); // adjust matches count
        avg_run(4, 2, 12'h800);
        // flush mid-average must drop the partial sum
        @(negedge clk_sys_in);
        flag_clr <= 1'b1;
        @(negedge clk_sys_in);
        flag_clr <= 1'b0;
        sample <= 12'hfff;
        pulse_evt(1'b1, 1'b0);
        wait_done();
        pulse_evt(1'b0, 1'b1);
        avg_run(4, 2, 12'h100); // flush clears
        n = starts;
        pulse_evt(1'b1, 1'b1);
        repeat (20) @(negedge clk_sys_in);
        check("flush beats start", starts - n, 0); // priority
        wr(IDX_AVERAGING, 16'h0045, 3); // adjust matches count
        avg_run(32, 5, 12'hf00); // shift code
        wr(IDX_CONTROL_C, 16'h0000, 3);
        for (int m = 0; m < 4; m++) begin
            keep_run <= m[0];
            on_req   <= m[1];
            standby  <= 1'b1;
            try_start(m[0]);
        end
        standby  <= 1'b0;
        keep_run <= 1'b0;
        try_start(1'b1);
        check("power off after", power, 0); // power down
        lat(n);
        check("wake delay", n > SU, 1); // start-up
        on_req <= 1'b0;
        lat(n);
        lat(n);
        check("powered start", n <= 2, 1); // powered
        wr(IDX_MAIN_CONTROL, 16'h0001, 3);
        check("soft reset main", applied[IDX_MAIN_CONTROL*REG_W +: REG_W], 0); // reset
        check("soft reset avg", applied[IDX_AVERAGING*REG_W +: REG_W], 0); // reset
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
